// ---- rtl/alu_pkg.sv ----
package alu_pkg;

  // ****************************************************************
  // Widths and constant bytes
  // ****************************************************************
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;

  // ****************************************************************
  // Status flag positions
  // ****************************************************************
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;

  // ****************************************************************
  // Execution times in clocks
  // ****************************************************************
  localparam int unsigned BYTE_CLOCKS = 1;
  localparam int unsigned WORD_CLOCKS = 2;

  // ****************************************************************
  // Operations and states
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_REG_SUM = 5'h00,
    OP_CARRY_SUM = 5'h01,
    OP_WORD_IMMEDIATE_SUM = 5'h02,
    OP_REG_DIFFERENCE = 5'h03,
    OP_CONSTANT_DIFFERENCE = 5'h04,
    OP_BORROW_DIFFERENCE = 5'h05,
    OP_CONSTANT_BORROW_DIFFERENCE = 5'h06,
    OP_WORD_IMMEDIATE_DIFFERENCE = 5'h07,
    OP_CONJUNCTION = 5'h08,
    OP_CONSTANT_CONJUNCTION = 5'h09,
    OP_DISJUNCTION = 5'h0A,
    OP_CONSTANT_DISJUNCTION = 5'h0B,
    OP_EXCLUSIVE_DISJUNCTION = 5'h0C,
    OP_ONES_COMPLEMENT = 5'h0D,
    OP_SIGN_FLIP = 5'h0E,
    OP_BIT_SET_MASK = 5'h0F,
    OP_BIT_CLEAR_MASK = 5'h10,
    OP_PLUS_ONE = 5'h11,
    OP_MINUS_ONE = 5'h12
  } alu_op_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WORD_HI = 1'b1
  } alu_state_t;

endpackage

// ---- rtl/alu_add_if.sv ----
`timescale 1ns/1ps
interface alu_add_if;
  logic [7:0] opa;
  logic [7:0] opb;
  logic carry_in;
  logic subtract;
  logic [7:0] sum;
  logic carry_out;
  logic half_carry;
  logic overflow;

  modport user (
    output opa,
    output opb,
    output carry_in,
    output subtract,
    input sum,
    input carry_out,
    input half_carry,
    input overflow
  );

  modport unit (
    input opa,
    input opb,
    input carry_in,
    input subtract,
    output sum,
    output carry_out,
    output half_carry,
    output overflow
  );
endinterface

// ---- rtl/alu_add.sv ----
`timescale 1ns/1ps
module alu_add (
  alu_add_if.unit add
);
  import alu_pkg::*;

  logic [7:0] opb_x;
  logic cin_x;
  logic [4:0] nib;
  logic [8:0] full;

  // ****************************************************************
  // Shared adder
  // ****************************************************************
  // Subtraction runs as a + ~b + ~borrow, so carries leave inverted
  // and are turned back into borrows here.
  always_comb begin
    opb_x = add.subtract ? ~add.opb : add.opb;
    cin_x = add.subtract ? ~add.carry_in : add.carry_in;
    nib = {1'b0, add.opa[3:0]} + {1'b0, opb_x[3:0]} + {4'h0, cin_x};
    full = {1'b0, add.opa} + {1'b0, opb_x} + {8'h00, cin_x};
    add.sum = full[7:0];
    add.carry_out = full[8] ^ add.subtract;
    add.half_carry = nib[4] ^ add.subtract;
    add.overflow = (add.opa[7] == opb_x[7]) && (full[7] != add.opa[7]);
  end

endmodule

// ---- rtl/alu_top.sv ----
`timescale 1ns/1ps
module alu_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire alu_pkg::alu_op_t req_op_i,
  input wire logic [alu_pkg::DATA_W-1:0] dst_i,
  input wire logic [alu_pkg::DATA_W-1:0] src_i,
  input wire logic [alu_pkg::DATA_W-1:0] dst_hi_i,
  input wire logic [alu_pkg::DATA_W-1:0] status_i,
  output logic ready_o,
  output logic done_o,
  output logic [alu_pkg::DATA_W-1:0] result_o,
  output logic [alu_pkg::DATA_W-1:0] result_hi_o,
  output logic pair_write_o,
  output logic [alu_pkg::DATA_W-1:0] status_o
);
  import alu_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;

  alu_state_t state_q;
  alu_state_t state_d;
  alu_op_t op_q;
  alu_op_t op_d;
  logic [7:0] lo_q;
  logic [7:0] lo_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic carry_q;
  logic carry_d;
  logic [7:0] base_q;
  logic [7:0] base_d;

  logic done_q;
  logic done_d;
  logic [7:0] res_q;
  logic [7:0] res_d;
  logic [7:0] res_hi_q;
  logic [7:0] res_hi_d;
  logic pair_q;
  logic pair_d;
  logic [7:0] stat_q;
  logic [7:0] stat_d;

  logic is_sub;
  logic is_word;
  logic [7:0] word_hi;
  logic word_neg;
  logic word_ovf;

  alu_add_if add ();

  alu_add u_add (
    .add(add)
  );

  // ****************************************************************
  // Reset release
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // Flag helpers
  // ****************************************************************
  function automatic logic [7:0] logic_flags(
    input logic [7:0] st,
    input logic [7:0] r
  );
    logic [7:0] f;
    f = st;
    f[FLAG_Z] = (r == ZERO_BYTE);
    f[FLAG_N] = r[7];
    f[FLAG_V] = 1'b0;
    return f;
  endfunction

  function automatic logic [7:0] arith_flags(
    input logic [7:0] st,
    input logic [7:0] r,
    input logic c,
    input logic h,
    input logic v
  );
    logic [7:0] f;
    f = st;
    f[FLAG_Z] = (r == ZERO_BYTE);
    f[FLAG_N] = r[7];
    f[FLAG_V] = v;
    f[FLAG_C] = c;
    f[FLAG_H] = h;
    return f;
  endfunction

  // ****************************************************************
  // Operation class
  // ****************************************************************
  always_comb begin
    is_word = 1'b0;
    is_sub = 1'b0;
    // Decoded from req_op_i, or from op_q in ST_WORD_HI, rather than op_d, so that the adder
    // output never loops back into its own steering.
    case ((state_q == ST_IDLE) ? req_op_i : op_q)
      OP_WORD_IMMEDIATE_SUM: begin
        is_word = 1'b1;
      end
      OP_WORD_IMMEDIATE_DIFFERENCE: begin
        is_word = 1'b1;
        is_sub = 1'b1;
      end
      OP_REG_DIFFERENCE, OP_CONSTANT_DIFFERENCE, OP_BORROW_DIFFERENCE,
      OP_CONSTANT_BORROW_DIFFERENCE, OP_SIGN_FLIP, OP_MINUS_ONE: begin
        is_sub = 1'b1;
      end
      default: begin
        is_sub = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Adder steering
  // ****************************************************************
  // The word operations reuse the byte adder on two clocks, low byte
  // first, which is why they cost the extra clock.
  always_comb begin
    add.opa = dst_i;
    add.opb = src_i;
    add.carry_in = 1'b0;
    add.subtract = is_sub;
    if (state_q == ST_WORD_HI) begin
      add.opa = hi_q;
      add.opb = ZERO_BYTE;
      add.carry_in = carry_q;
    end else begin
      case (req_op_i)
        OP_CARRY_SUM, OP_BORROW_DIFFERENCE,
        OP_CONSTANT_BORROW_DIFFERENCE: begin
          add.carry_in = status_i[FLAG_C];
        end
        OP_SIGN_FLIP: begin
          add.opa = ZERO_BYTE;
          add.opb = dst_i;
        end
        OP_PLUS_ONE, OP_MINUS_ONE: begin
          add.opb = ONE_BYTE;
        end
        default: begin
          add.carry_in = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Word high byte flags
  // ****************************************************************
  always_comb begin
    word_hi = add.sum;
    word_neg = add.sum[7];
    word_ovf = add.overflow;
  end

  // ****************************************************************
  // Sequencer and result next values
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    lo_d = lo_q;
    hi_d = hi_q;
    carry_d = carry_q;
    base_d = base_q;
    done_d = 1'b0;
    res_d = res_q;
    res_hi_d = res_hi_q;
    pair_d = 1'b0;
    stat_d = stat_q;
    if (state_q == ST_IDLE) begin
      op_d = req_op_i;
    end
    case (state_q)
      ST_IDLE: begin
        if (req_valid_i && is_word) begin
          lo_d = add.sum;
          carry_d = add.carry_out;
          hi_d = dst_hi_i;
          base_d = status_i;
          state_d = ST_WORD_HI;
        end else if (req_valid_i) begin
          done_d = 1'b1;
          res_hi_d = ZERO_BYTE;
          res_d = add.sum;
          stat_d = arith_flags(status_i, add.sum, add.carry_out,
                               add.half_carry, add.overflow);
          case (req_op_i)
            OP_REG_SUM, OP_CARRY_SUM: begin
              res_d = add.sum;
            end
            OP_REG_DIFFERENCE, OP_CONSTANT_DIFFERENCE: begin
              res_d = add.sum;
            end
            OP_BORROW_DIFFERENCE, OP_CONSTANT_BORROW_DIFFERENCE: begin
              res_d = add.sum;
            end
            OP_CONJUNCTION, OP_CONSTANT_CONJUNCTION: begin
              res_d = dst_i & src_i;
              stat_d = logic_flags(status_i, dst_i & src_i);
            end
            OP_DISJUNCTION, OP_CONSTANT_DISJUNCTION: begin
              res_d = dst_i | src_i;
              stat_d = logic_flags(status_i, dst_i | src_i);
            end
            OP_EXCLUSIVE_DISJUNCTION: begin
              res_d = dst_i ^ src_i;
              stat_d = logic_flags(status_i, dst_i ^ src_i);
            end
            OP_BIT_SET_MASK: begin
              res_d = dst_i | src_i;
              stat_d = logic_flags(status_i, dst_i | src_i);
            end
            OP_BIT_CLEAR_MASK: begin
              res_d = dst_i & (ALL_ONES - src_i);
              stat_d = logic_flags(status_i, dst_i & (ALL_ONES - src_i));
            end
            OP_ONES_COMPLEMENT: begin
              res_d = ALL_ONES - dst_i;
              stat_d = logic_flags(status_i, ALL_ONES - dst_i);
              stat_d[FLAG_C] = 1'b1;
            end
            OP_SIGN_FLIP: begin
              res_d = add.sum;
            end
            OP_PLUS_ONE, OP_MINUS_ONE: begin
              res_d = add.sum;
              stat_d = logic_flags(status_i, add.sum);
              stat_d[FLAG_V] = add.overflow;
            end
            default: begin
              res_d = add.sum;
            end
          endcase
        end
      end
      ST_WORD_HI: begin
        done_d = 1'b1;
        pair_d = 1'b1;
        res_d = lo_q;
        res_hi_d = word_hi;
        stat_d = base_q;
        stat_d[FLAG_Z] = ({word_hi, lo_q} == {ZERO_BYTE, ZERO_BYTE});
        stat_d[FLAG_C] = add.carry_out;
        stat_d[FLAG_N] = word_neg;
        stat_d[FLAG_V] = word_ovf;
        stat_d[FLAG_S] = word_neg ^ word_ovf;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      op_q <= OP_REG_SUM;
      lo_q <= RESULT_RST;
      hi_q <= RESULT_RST;
      carry_q <= 1'b0;
      base_q <= STATUS_RST;
      done_q <= 1'b0;
      res_q <= RESULT_RST;
      res_hi_q <= RESULT_RST;
      pair_q <= 1'b0;
      stat_q <= STATUS_RST;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      carry_q <= carry_d;
      base_q <= base_d;
      done_q <= done_d;
      res_q <= res_d;
      res_hi_q <= res_hi_d;
      pair_q <= pair_d;
      stat_q <= stat_d;
    end
  end

  // A word operation blocks new requests for its second clock only.
  assign ready_o = (state_q == ST_IDLE);
  assign done_o = done_q;
  assign result_o = res_q;
  assign result_hi_o = res_hi_q;
  assign pair_write_o = pair_q;
  assign status_o = stat_q;

endmodule

// ---- bench/alu_sva.sv ----
`timescale 1ns/1ps
module alu_sva
  import alu_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire alu_op_t req_op_i,
  input wire logic [7:0] dst_i,
  input wire logic [7:0] src_i,
  input wire logic [7:0] dst_hi_i,
  input wire logic [7:0] status_i,
  input wire logic ready_o,
  input wire logic done_o,
  input wire logic [7:0] result_o,
  input wire logic [7:0] result_hi_o,
  input wire logic pair_write_o,
  input wire logic [7:0] status_o
);
  logic take;
  assign take = req_valid_i && ready_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_byte_sum: assert property (
    take && req_op_i == OP_REG_SUM |=> done_o && !pair_write_o &&
    result_o == $past(dst_i) + $past(src_i)) else $error("sum wrong");
  a_word_two: assert property (
    take && (req_op_i == OP_WORD_IMMEDIATE_SUM ||
    req_op_i == OP_WORD_IMMEDIATE_DIFFERENCE) |=> !ready_o && !done_o
    ##1 done_o && pair_write_o && ready_o) else $error("word timing");
  a_word_sum: assert property (
    take && req_op_i == OP_WORD_IMMEDIATE_SUM |=> ##1
    {result_hi_o, result_o} == {$past(dst_hi_i, 2), $past(dst_i, 2)} +
    16'($past(src_i, 2))) else $error("word sum wrong");
  a_sub_borrow: assert property (
    take && req_op_i == OP_REG_DIFFERENCE |=>
    status_o[FLAG_C] == ($past(src_i) > $past(dst_i)))
    else $error("borrow wrong");
  a_and_flags: assert property (
    take && req_op_i == OP_CONJUNCTION |=> !status_o[FLAG_V] &&
    result_o == ($past(dst_i) & $past(src_i))) else $error("and wrong");
  a_xor_zero: assert property (
    take && req_op_i == OP_EXCLUSIVE_DISJUNCTION |=>
    status_o[FLAG_Z] == ($past(dst_i) == $past(src_i)))
    else $error("xor zero wrong");
  a_clear_mask: assert property (
    take && req_op_i == OP_BIT_CLEAR_MASK |=>
    result_o == ($past(dst_i) & (8'hFF - $past(src_i))))
    else $error("clear mask wrong");
  a_inc_carry: assert property (
    take && req_op_i == OP_PLUS_ONE |=> result_o == $past(dst_i) + 8'h01
    && status_o[FLAG_C] == $past(status_i[FLAG_C]))
    else $error("increment wrong");
endmodule

// ---- bench/alu_partner.sv ----
`timescale 1ns/1ps
// Holds the status byte as the core would; the bench may preload it.
module alu_partner (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic done_i,
  input wire logic [7:0] new_status_i,
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  output logic [7:0] status_o
);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= 8'h00;
    end else if (load_i) begin
      status_o <= load_val_i;
    end else if (done_i) begin
      status_o <= new_status_i;
    end
  end
endmodule

// ---- bench/test_arith_logic_unit_8bit.sv ----
`timescale 1ns/1ps
module test_arith_logic_unit_8bit;
  import alu_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, ld = 1'b0, rdy, dn, pw;
  alu_op_t op = OP_REG_SUM;
  logic [7:0] dst = 8'h00, src = 8'h00, hi = 8'h00, ldv = 8'h00;
  logic [7:0] st, res, rhi, sto;
  int errors = 0, tests_run = 0, cyc = 0;
  always #4 clk = ~clk;
  alu_top dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(vld),
    .req_op_i(op), .dst_i(dst), .src_i(src), .dst_hi_i(hi), .status_i(st),
    .ready_o(rdy), .done_o(dn), .result_o(res), .result_hi_o(rhi),
    .pair_write_o(pw), .status_o(sto));
  alu_partner part_u (.clk_i(clk), .rst_n_i(rst_n), .done_i(dn),
    .new_status_i(sto), .load_i(ld), .load_val_i(ldv), .status_o(st));
  // ****************************************************************
  // Shared request and compare tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [7:0] e, v);
    tests_run++;
    if (v !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic run(input alu_op_t o, input logic [7:0] d, s, h, p,
                     er, eh, m, es);
    logic w;
    w = (o == OP_WORD_IMMEDIATE_SUM || o == OP_WORD_IMMEDIATE_DIFFERENCE);
    @(posedge clk);
    ld <= 1'b1;
    ldv <= p;
    @(posedge clk);
    ld <= 1'b0;
    vld <= 1'b1;
    op <= o;
    dst <= d;
    src <= s;
    hi <= h;
    @(posedge clk);
    vld <= 1'b0;
    if (w) begin
      #1;
      chk("ready", 8'h00, 8'(rdy));
      chk("done_early", 8'h00, 8'(dn));
      @(posedge clk);
    end
    #1;
    chk("done", 8'h01, 8'(dn));
    chk("ready_after", 8'h01, 8'(rdy));
    chk("pair", 8'(w), 8'(pw));
    chk("result", er, res);
    chk("result_hi", eh, rhi);
    chk("status", es & m, sto & m);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_add();
    run(OP_REG_SUM, 8'h7F, 8'h01, 8'h00, 8'h00,
        8'h80, 8'h00, 8'h2F, 8'h2C);
    run(OP_CARRY_SUM, 8'hFF, 8'h00, 8'h00, 8'h01,
        8'h00, 8'h00, 8'h2F, 8'h23);
  endtask
  task automatic t_word();
    run(OP_WORD_IMMEDIATE_SUM, 8'hFF, 8'h01, 8'h7F, 8'h20,
        8'h00, 8'h80, 8'h3F, 8'h2C);
    run(OP_WORD_IMMEDIATE_DIFFERENCE, 8'h00, 8'h01, 8'h00,
        8'h00, 8'hFF, 8'hFF, 8'h1F, 8'h15);
  endtask
  task automatic t_sub();
    run(OP_REG_DIFFERENCE, 8'h10, 8'h20, 8'h00, 8'h00,
        8'hF0, 8'h00, 8'h2F, 8'h05);
    run(OP_CONSTANT_DIFFERENCE, 8'h05, 8'h05, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h2F, 8'h02);
    run(OP_BORROW_DIFFERENCE, 8'h00, 8'h00, 8'h00, 8'h01,
        8'hFF, 8'h00, 8'h2F, 8'h25);
    run(OP_CONSTANT_BORROW_DIFFERENCE, 8'h80, 8'h00, 8'h00,
        8'h01, 8'h7F, 8'h00, 8'h2F, 8'h28);
  endtask
  task automatic t_logic();
    run(OP_CONJUNCTION, 8'hC3, 8'h3C, 8'h00, 8'h08,
        8'h00, 8'h00, 8'h0E, 8'h02);
    run(OP_CONSTANT_CONJUNCTION, 8'hC3, 8'h0F, 8'h00, 8'h08,
        8'h03, 8'h00, 8'h0E, 8'h00);
    run(OP_DISJUNCTION, 8'hC3, 8'h0F, 8'h00, 8'h08,
        8'hCF, 8'h00, 8'h0E, 8'h04);
    run(OP_CONSTANT_DISJUNCTION, 8'h00, 8'h00, 8'h00, 8'h08,
        8'h00, 8'h00, 8'h0E, 8'h02);
    run(OP_EXCLUSIVE_DISJUNCTION, 8'hC3, 8'hC3, 8'h00, 8'h08,
        8'h00, 8'h00, 8'h0E, 8'h02);
    run(OP_BIT_SET_MASK, 8'h03, 8'h80, 8'h00, 8'h08,
        8'h83, 8'h00, 8'h0E, 8'h04);
    run(OP_BIT_CLEAR_MASK, 8'hC3, 8'h0F, 8'h00, 8'h08,
        8'hC0, 8'h00, 8'h0E, 8'h04);
  endtask
  task automatic t_unary();
    run(OP_ONES_COMPLEMENT, 8'h00, 8'h00, 8'h00, 8'h08,
        8'hFF, 8'h00, 8'h0F, 8'h05);
    run(OP_SIGN_FLIP, 8'h01, 8'h00, 8'h00, 8'h00,
        8'hFF, 8'h00, 8'h2F, 8'h25);
    run(OP_SIGN_FLIP, 8'h80, 8'h00, 8'h00, 8'h00,
        8'h80, 8'h00, 8'h2F, 8'h0D);
    run(OP_PLUS_ONE, 8'h7F, 8'h00, 8'h00, 8'h21,
        8'h80, 8'h00, 8'h2F, 8'h2D);
    run(OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 8'h01,
        8'h7F, 8'h00, 8'h2F, 8'h09);
  endtask
  // A request held up while a word operation runs must be dropped, and
  // byte operations must be taken on consecutive edges.
  task automatic t_order();
    @(posedge clk);
    vld <= 1'b1;
    op <= OP_WORD_IMMEDIATE_SUM;
    dst <= 8'hFE;
    src <= 8'h03;
    hi <= 8'h12;
    @(posedge clk);
    op <= OP_REG_SUM;
    dst <= 8'h55;
    @(posedge clk);
    vld <= 1'b0;
    #1;
    chk("order_word", 8'h01, res);
    chk("order_word_hi", 8'h13, rhi);
    chk("order_word_done", 8'h01, 8'(dn));
    @(posedge clk);
    vld <= 1'b1;
    dst <= 8'h01;
    src <= 8'h01;
    #1;
    chk("order_refused", 8'h00, 8'(dn));
    chk("order_refused_res", 8'h01, res);
    @(posedge clk);
    op <= OP_EXCLUSIVE_DISJUNCTION;
    dst <= 8'hF0;
    src <= 8'h0F;
    #1;
    chk("order_first", 8'h02, res);
    @(posedge clk);
    vld <= 1'b0;
    #1;
    chk("order_second", 8'hFF, res);
    chk("order_second_done", 8'h01, 8'(dn));
  endtask
  // A reset after an operation must clear every output but ready_o and leave the block usable.
  task automatic t_reset();
    run(OP_REG_SUM, 8'h7F, 8'h01, 8'h00, 8'h00,
        8'h80, 8'h00, 8'h2F, 8'h2C);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) begin
      @(posedge clk);
      #1;
      chk("rst_ready", 8'h01, 8'(rdy));
      chk("rst_done", 8'h00, 8'(dn));
      chk("rst_pair", 8'h00, 8'(pw));
      chk("rst_result", 8'h00, res);
      chk("rst_result_hi", 8'h00, rhi);
      chk("rst_status", 8'h00, sto);
    end
    run(OP_SIGN_FLIP, 8'h01, 8'h00, 8'h00, 8'h00,
        8'hFF, 8'h00, 8'h2F, 8'h25);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // A hang would stall the run; cut it far past the expected length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    t_add();
    t_word();
    t_sub();
    t_logic();
    t_unary();
    t_order();
    t_reset();
    end_of_test();
  end
endmodule
bind alu_top alu_sva sva_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .req_valid_i(req_valid_i), .req_op_i(req_op_i), .dst_i(dst_i),
  .src_i(src_i), .dst_hi_i(dst_hi_i), .status_i(status_i),
  .ready_o(ready_o), .done_o(done_o), .result_o(result_o),
  .result_hi_o(result_hi_o), .pair_write_o(pair_write_o),
  .status_o(status_o));
